/* File: verilog/spc_pkg.sv */
// What this block does
// [RQ1] five identical secondary clocks, up to 33 MHz
// [RQ2] secondary clocks stop with primary clock
// [RQ3] feedback clock input aligns internal timing
// [RQ4] reset held from power-up until dock release
// [RQ5] reset asserts at once, releases on clock
// [RQ6] parity is even over address/data and command
// [RQ7] command in address phase, byte enables after
// [RQ8] subtractive claim; configuration claimed at medium timing
// [RQ9] four requests, at most one grant
// [RQ10] parity-error line sampled as input
// [RQ11] system-error line sampled as input
// [RQ12] shared clock-run line keeps clocks running
// [RQ13] route flag tells ISA bridge transaction path
// [RQ14] presence strap high means ISA bridge fitted
// [RQ15] primary system error pulses one clock
// [RQ16] dock machine steps on slow clock
// [RQ17] rotating priority prevents grant starvation
`default_nettype none
package spc_pkg;
    // -----------------------------------------------------------------
    // sizes and timing
    // -----------------------------------------------------------------
    localparam int SPC_NUM_CLOCKS = 5;
    localparam int SPC_NUM_MASTERS = 4;
    localparam int SPC_PRI_CLK_MAX_MHZ = 33;
    localparam logic [2:0] SPC_DOCK_HOLD_TICKS = 3'h4;
    // claim points, counted in secondary edges after the address phase
    localparam logic [2:0] SPC_DECODE_MEDIUM = 3'h2;
    localparam logic [2:0] SPC_DECODE_SUBTRACTIVE = 3'h4;
    // configuration commands
    localparam logic [3:0] SPC_CMD_CFG_READ = 4'hA;
    localparam logic [3:0] SPC_CMD_CFG_WRITE = 4'hB;
    // reset values
    localparam logic [3:0] SPC_GNT_IDLE_N = 4'hF;
    localparam logic [1:0] SPC_RR_RESET = 2'h3;

    typedef enum logic [1:0] {SPC_DOCK_HOLD, SPC_DOCK_COUNT, SPC_DOCK_RUN} spc_dock_t;
    typedef enum logic [1:0] {SPC_DEC_IDLE, SPC_DEC_WAIT, SPC_DEC_CLAIM, SPC_DEC_OTHER} spc_dec_t;

    // even parity bit: makes the 37-bit total carry an even count of ones
    function automatic logic spc_even_parity(input logic [31:0] ad, input logic [3:0] cbe);
        return ^{ad, cbe};
    endfunction : spc_even_parity
endpackage : spc_pkg
`default_nettype wire

/* File: verilog/spc_port.sv */
`timescale 1ns/10ps
`default_nettype none
module spc_port (
    // clock and reset
    input wire logic core_clk_i,
    input wire logic rst_i,
    // clocks
    input wire logic pri_clock_i,
    input wire logic sec_clock_feedback_i,
    input wire logic dock_slow_clock_i,
    output logic [4:0] sec_clock_out_o,
    // docking control
    input wire logic dock_release_i,
    output logic sec_reset_n_o,
    // forwarded address/data drive
    input wire logic [31:0] fwd_ad_i,
    input wire logic [3:0] fwd_cmd_byte_en_n_i,
    input wire logic fwd_drive_i,
    output logic [31:0] sec_ad_o,
    output logic sec_ad_oe_o,
    output logic [3:0] sec_cmd_byte_en_n_o,
    output logic sec_cmd_byte_en_oe_o,
    output logic sec_parity_o,
    output logic sec_parity_oe_o,
    // secondary bus observation
    input wire logic sec_frame_n_i,
    input wire logic sec_irdy_n_i,
    input wire logic [3:0] sec_cmd_byte_en_n_i,
    input wire logic sec_dev_select_n_i,
    output logic sec_dev_select_n_o,
    output logic sec_dev_select_oe_o,
    // arbitration
    input wire logic [3:0] sec_req_n_i,
    output logic [3:0] sec_gnt_n_o,
    // errors
    input wire logic sec_parity_error_n_i,
    input wire logic sec_system_error_n_i,
    output logic pri_system_error_n_o,
    output logic pri_system_error_oe_o,
    // clock run
    input wire logic sec_clock_run_n_i,
    output logic sec_clock_run_n_o,
    output logic sec_clock_run_oe_o,
    output logic sec_clocks_may_stop_o,
    // isa bridge sideband
    input wire logic isa_bridge_present_i,
    output logic isa_bridge_route_flag_o
);
    // -----------------------------------------------------------------
    // state
    // -----------------------------------------------------------------
    typedef struct packed {
        logic [4:0] clk_out;
        logic fb_prev;
        logic dock_prev;
        spc_pkg::spc_dock_t dock;
        logic [2:0] ticks;
        logic rst_n;
        logic [31:0] ad;
        logic ad_oe;
        logic [3:0] cbe;
        logic par;
        logic par_oe;
        logic frame_prev;
        spc_pkg::spc_dec_t dec;
        logic [2:0] dec_cnt;
        logic cfg;
        logic devsel_oe;
        logic route;
        logic [3:0] gnt_n;
        logic [1:0] rr_last;
        logic perr_prev;
        logic serr_prev;
        logic serr_oe;
        logic clkrun_oe;
        logic may_stop;
    } spc_state_t;

    localparam spc_state_t SPC_RESET_STATE = '{
        clk_out: 5'h00, fb_prev: 1'b0, dock_prev: 1'b0, dock: spc_pkg::SPC_DOCK_HOLD,
        ticks: 3'h0, rst_n: 1'b0, ad: 32'h0000_0000, ad_oe: 1'b0, cbe: 4'hF,
        par: 1'b0, par_oe: 1'b0, frame_prev: 1'b1, dec: spc_pkg::SPC_DEC_IDLE,
        dec_cnt: 3'h0, cfg: 1'b0, devsel_oe: 1'b0, route: 1'b0,
        gnt_n: spc_pkg::SPC_GNT_IDLE_N, rr_last: spc_pkg::SPC_RR_RESET,
        perr_prev: 1'b1, serr_prev: 1'b1, serr_oe: 1'b0, clkrun_oe: 1'b1,
        may_stop: 1'b0};

    spc_state_t st, next_st;
    logic sec_edge, dock_edge, bus_idle, err_event;

    // -----------------------------------------------------------------
    // next-state logic
    // -----------------------------------------------------------------
    always_comb begin
        logic found;
        logic [1:0] idx, pick;
        found = 1'b0;
        idx = 2'h0;
        pick = st.rr_last;
        next_st = st;
        sec_edge = sec_clock_feedback_i & ~st.fb_prev; // RQ3
        dock_edge = dock_slow_clock_i & ~st.dock_prev; // RQ16
        bus_idle = sec_frame_n_i & sec_irdy_n_i;
        err_event = (~sec_parity_error_n_i & st.perr_prev) | (~sec_system_error_n_i & st.serr_prev);
        next_st.fb_prev = sec_clock_feedback_i;
        next_st.dock_prev = dock_slow_clock_i;
        // image of the primary clock on every output, so a stopped primary stops them all
        next_st.clk_out = {5{pri_clock_i}}; // RQ1 RQ2

        // dock machine: release only after a stable request over several slow ticks
        if (dock_edge) begin
            unique case (st.dock)
                spc_pkg::SPC_DOCK_HOLD: begin
                    next_st.ticks = 3'h0;
                    if (dock_release_i) begin
                        next_st.dock = spc_pkg::SPC_DOCK_COUNT;
                    end
                end
                spc_pkg::SPC_DOCK_COUNT: begin
                    next_st.ticks = st.ticks + 3'h1;
                    if (!dock_release_i) begin
                        next_st.dock = spc_pkg::SPC_DOCK_HOLD;
                    end else if (st.ticks == spc_pkg::SPC_DOCK_HOLD_TICKS - 3'h1) begin
                        next_st.dock = spc_pkg::SPC_DOCK_RUN;
                    end
                end
                spc_pkg::SPC_DOCK_RUN: begin
                    if (!dock_release_i) begin
                        next_st.dock = spc_pkg::SPC_DOCK_HOLD;
                    end
                end
                default: next_st.dock = spc_pkg::SPC_DOCK_HOLD;
            endcase
        end
        // reset asserts at once outside run, releases only on a secondary edge
        if (next_st.dock != spc_pkg::SPC_DOCK_RUN) begin
            next_st.rst_n = 1'b0; // RQ4
        end else if (sec_edge) begin
            next_st.rst_n = 1'b1; // RQ5
        end

        if (sec_edge) begin
            // forwarded drive; parity follows one clock behind its data
            next_st.ad = fwd_ad_i;
            next_st.cbe = fwd_cmd_byte_en_n_i; // RQ7
            next_st.ad_oe = fwd_drive_i & st.rst_n;
            next_st.par = spc_pkg::spc_even_parity(st.ad, st.cbe); // RQ6
            next_st.par_oe = st.ad_oe;
            next_st.frame_prev = sec_frame_n_i;

            // decode: others get fast..slow, we take what is left; configuration we claim at medium
            unique case (st.dec)
                spc_pkg::SPC_DEC_IDLE: begin
                    if (!sec_frame_n_i && st.frame_prev) begin
                        next_st.dec = spc_pkg::SPC_DEC_WAIT;
                        next_st.dec_cnt = 3'h0;
                        next_st.cfg = (sec_cmd_byte_en_n_i == spc_pkg::SPC_CMD_CFG_READ) ||
                                      (sec_cmd_byte_en_n_i == spc_pkg::SPC_CMD_CFG_WRITE);
                    end
                end
                spc_pkg::SPC_DEC_WAIT: begin
                    next_st.dec_cnt = st.dec_cnt + 3'h1;
                    if (!sec_dev_select_n_i) begin
                        next_st.dec = spc_pkg::SPC_DEC_OTHER;
                    end else if (st.dec_cnt + 3'h1 == (st.cfg ? spc_pkg::SPC_DECODE_MEDIUM
                                                    : spc_pkg::SPC_DECODE_SUBTRACTIVE)) begin
                        next_st.dec = spc_pkg::SPC_DEC_CLAIM; // RQ8
                        next_st.devsel_oe = 1'b1;
                        // claimed downstream traffic goes to the isa bridge only if fitted
                        next_st.route = ~st.cfg & isa_bridge_present_i; // RQ13 RQ14
                    end
                end
                spc_pkg::SPC_DEC_CLAIM, spc_pkg::SPC_DEC_OTHER: begin
                    if (bus_idle) begin
                        next_st.dec = spc_pkg::SPC_DEC_IDLE;
                        next_st.devsel_oe = 1'b0;
                        next_st.route = 1'b0;
                    end
                end
            endcase

            // arbitration between transactions, searching from the one after the last winner onward
            if (bus_idle) begin
                for (int i = 1; i <= 4; i++) begin
                    idx = st.rr_last + 2'(i);
                    if (!found && !sec_req_n_i[idx]) begin
                        found = 1'b1;
                        pick = idx;
                    end
                end
                next_st.gnt_n = spc_pkg::SPC_GNT_IDLE_N; // RQ9
                if (found && st.rst_n) begin
                    next_st.gnt_n[pick] = 1'b0;
                    next_st.rr_last = pick; // RQ17
                end
            end

            // error lines sampled; a fresh assertion gives one primary-clock pulse
            next_st.perr_prev = sec_parity_error_n_i; // RQ10
            next_st.serr_prev = sec_system_error_n_i; // RQ11
            next_st.serr_oe = err_event; // RQ15
        end
        // keep clocks running while anything is pending on the secondary side
        next_st.clkrun_oe = (next_st.dec != spc_pkg::SPC_DEC_IDLE) | ~(&sec_req_n_i) |
                            ~next_st.rst_n | next_st.serr_oe; // RQ12
        next_st.may_stop = sec_clock_run_n_i & ~next_st.clkrun_oe;
    end
    // state register
    always_ff @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
            st <= SPC_RESET_STATE;
        end else begin
            st <= next_st;
        end
    end

    // -----------------------------------------------------------------
    // outputs
    // -----------------------------------------------------------------
    assign sec_clock_out_o = st.clk_out;
    assign sec_reset_n_o = st.rst_n;
    assign sec_ad_o = st.ad;
    assign sec_ad_oe_o = st.ad_oe;
    assign sec_cmd_byte_en_n_o = st.cbe;
    assign sec_cmd_byte_en_oe_o = st.ad_oe;
    assign sec_parity_o = st.par;
    assign sec_parity_oe_o = st.par_oe;
    assign sec_dev_select_n_o = ~st.devsel_oe;
    assign sec_dev_select_oe_o = st.devsel_oe;
    assign sec_gnt_n_o = st.gnt_n;
    assign pri_system_error_n_o = ~st.serr_oe;
    assign pri_system_error_oe_o = st.serr_oe;
    assign sec_clock_run_n_o = ~st.clkrun_oe;
    assign sec_clock_run_oe_o = st.clkrun_oe;
    assign sec_clocks_may_stop_o = st.may_stop;
    assign isa_bridge_route_flag_o = st.route;

    // -----------------------------------------------------------------
    // assertions
    // -----------------------------------------------------------------
    default clocking cb @(posedge core_clk_i); endclocking
    default disable iff (rst_i);

    property p_clk_identical;
        !$past(rst_i) |-> sec_clock_out_o == {5{$past(pri_clock_i)}};
    endproperty
    a_clk_identical: assert property (p_clk_identical) // RQ1
        else $error("secondary clock copies differ from primary image");
    property p_clk_stop;
        !pri_clock_i ##1 !pri_clock_i |=> sec_clock_out_o == 5'h00;
    endproperty
    a_clk_stop: assert property (p_clk_stop) // RQ2
        else $error("secondary clocks run with primary stopped");
    property p_rst_release_edge;
        $rose(sec_reset_n_o) |-> $past(sec_clock_feedback_i) && !$past(st.fb_prev);
    endproperty
    a_rst_release_edge: assert property (p_rst_release_edge) // RQ5
        else $error("secondary reset released off a clock edge");
    property p_rst_hold;
        st.dock != spc_pkg::SPC_DOCK_RUN |-> !sec_reset_n_o;
    endproperty
    a_rst_hold: assert property (p_rst_hold) // RQ4
        else $error("secondary reset released before dock run");
    property p_parity;
        sec_edge && st.ad_oe |=> sec_parity_oe_o &&
            sec_parity_o == spc_pkg::spc_even_parity($past(sec_ad_o), $past(sec_cmd_byte_en_n_o));
    endproperty
    a_parity: assert property (p_parity) // RQ6
        else $error("secondary parity not even");
    property p_claim_timing;
        $rose(sec_dev_select_oe_o) |-> st.dec_cnt == (st.cfg ? spc_pkg::SPC_DECODE_MEDIUM
                                                     : spc_pkg::SPC_DECODE_SUBTRACTIVE);
    endproperty
    a_claim_timing: assert property (p_claim_timing) // RQ8
        else $error("device select claimed at wrong decode point");
    property p_one_grant;
        $onehot0(~sec_gnt_n_o);
    endproperty
    a_one_grant: assert property (p_one_grant) // RQ9
        else $error("more than one grant active");
    property pri_system_error_n_pulse;
        $changed(pri_system_error_oe_o) |-> $past(sec_edge) && (!pri_system_error_oe_o ||
            $past(!sec_parity_error_n_i || !sec_system_error_n_i));
    endproperty
    a_serr_pulse: assert property (pri_system_error_n_pulse) // RQ15
        else $error("primary system error pulse misaligned or uncaused");
    property p_route_present;
        $rose(isa_bridge_route_flag_o) |-> $past(isa_bridge_present_i) && sec_dev_select_oe_o;
    endproperty
    a_route_present: assert property (p_route_present) // RQ14
        else $error("route flag without bridge present");
    property p_clkrun_busy;
        sec_dev_select_oe_o |-> sec_clock_run_oe_o;
    endproperty
    a_clkrun_busy: assert property (p_clkrun_busy) // RQ12
        else $error("clock run released during claimed transaction");
endmodule : spc_port
`default_nettype wire

/* File: bench/spc_sec_agent.sv */
`timescale 1ns/10ps
`default_nettype none
module spc_sec_agent (
    // design side of the shared lines
    input wire logic dsel_oe_i,
    input wire logic dsel_n_i,
    input wire logic run_oe_i,
    // lines seen by the design
    output logic frame_n_o,
    output logic irdy_n_o,
    output logic [3:0] cbe_n_o,
    output logic dsel_line_o,
    output logic [3:0] req_n_o,
    output logic perr_n_o,
    output logic serr_n_o,
    output logic run_line_o
);
    // ----------
    // other agents on the secondary bus
    // ----------
    logic other_dsel_n;
    logic run_hold_n;
    // idle bus at time zero
    initial begin
        frame_n_o = 1'b1;
        irdy_n_o = 1'b1;
        cbe_n_o = 4'hF;
        req_n_o = 4'hF;
        perr_n_o = 1'b1;
        serr_n_o = 1'b1;
        other_dsel_n = 1'b1;
        run_hold_n = 1'b1;
    end
    // pulled-up shared lines
    assign dsel_line_o = dsel_oe_i ? dsel_n_i : other_dsel_n;
    assign run_line_o = ~run_oe_i & run_hold_n;
    // address phase carries the command
    task automatic addr_phase(input logic [3:0] cmd, input logic other);
        frame_n_o <= 1'b0;
        cbe_n_o <= cmd;
        other_dsel_n <= ~other;
    endtask : addr_phase
    // single last data phase with byte enables
    task automatic data_phase(input logic [3:0] be);
        frame_n_o <= 1'b1;
        irdy_n_o <= 1'b0;
        cbe_n_o <= be;
    endtask : data_phase
    // released lanes show the inverse of their last value
    task automatic release_bus();
        irdy_n_o <= 1'b1;
        cbe_n_o <= ~cbe_n_o;
        other_dsel_n <= 1'b1;
    endtask : release_bus
    // requests, error reports and clock hold
    task automatic set_side(input logic [3:0] req, input logic perr, input logic serr,
                            input logic hold);
        req_n_o <= req;
        perr_n_o <= perr;
        serr_n_o <= serr;
        run_hold_n <= hold;
    endtask : set_side
endmodule : spc_sec_agent
`default_nettype wire

/* File: bench/tb.sv */
`timescale 1ns/10ps
`default_nettype none
module tb;
    // ----------
    // stimulus, design and far side
    // ----------
    logic core_clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic pri_clock_i = 1'b0;
    logic dock_slow_clock_i = 1'b0;
    logic dock_release_i = 1'b0;
    logic isa_bridge_present_i = 1'b0;
    logic fwd_drive_i = 1'b0;
    logic [31:0] fwd_ad_i = 32'h0;
    logic [3:0] fwd_cmd_byte_en_n_i = 4'hF;
    logic pri_run = 1'b1;
    logic [2:0] pc = 3'h0;
    logic [6:0] dc = 7'h0;
    logic fb_q = 1'b0;
    logic pri_q = 1'b0;
    logic prev_par = 1'b0;
    logic prev_valid = 1'b0;
    logic [35:0] exp_q[$];
    int error_cnt = 0;
    int n_compared = 0;
    int cycles = 0;
    wire logic [4:0] sec_clock_out_o;
    wire logic [31:0] sec_ad_o;
    wire logic [3:0] sec_cmd_byte_en_n_o, sec_gnt_n_o, sec_cmd_byte_en_n_i, sec_req_n_i;
    wire logic sec_reset_n_o, sec_ad_oe_o, sec_cmd_byte_en_oe_o, sec_parity_o, sec_parity_oe_o;
    wire logic sec_dev_select_n_o, sec_dev_select_oe_o, pri_system_error_n_o;
    wire logic pri_system_error_oe_o, sec_clock_run_n_o, sec_clock_run_oe_o;
    wire logic sec_clocks_may_stop_o, isa_bridge_route_flag_o, sec_frame_n_i, sec_irdy_n_i;
    wire logic sec_dev_select_n_i, sec_parity_error_n_i, sec_system_error_n_i, sec_clock_run_n_i;

    spc_port i_spc_port (
        .core_clk_i, .rst_i, .pri_clock_i, .sec_clock_feedback_i(sec_clock_out_o[0]),
        .dock_slow_clock_i, .sec_clock_out_o, .dock_release_i, .sec_reset_n_o,
        .fwd_ad_i, .fwd_cmd_byte_en_n_i, .fwd_drive_i, .sec_ad_o, .sec_ad_oe_o,
        .sec_cmd_byte_en_n_o, .sec_cmd_byte_en_oe_o, .sec_parity_o, .sec_parity_oe_o,
        .sec_frame_n_i, .sec_irdy_n_i, .sec_cmd_byte_en_n_i, .sec_dev_select_n_i,
        .sec_dev_select_n_o, .sec_dev_select_oe_o, .sec_req_n_i, .sec_gnt_n_o,
        .sec_parity_error_n_i, .sec_system_error_n_i, .pri_system_error_n_o,
        .pri_system_error_oe_o, .sec_clock_run_n_i, .sec_clock_run_n_o, .sec_clock_run_oe_o,
        .sec_clocks_may_stop_o, .isa_bridge_present_i, .isa_bridge_route_flag_o
    );
    spc_sec_agent i_spc_sec_agent (
        .dsel_oe_i(sec_dev_select_oe_o), .dsel_n_i(sec_dev_select_n_o),
        .run_oe_i(sec_clock_run_oe_o), .frame_n_o(sec_frame_n_i), .irdy_n_o(sec_irdy_n_i),
        .cbe_n_o(sec_cmd_byte_en_n_i), .dsel_line_o(sec_dev_select_n_i), .req_n_o(sec_req_n_i),
        .perr_n_o(sec_parity_error_n_i), .serr_n_o(sec_system_error_n_i),
        .run_line_o(sec_clock_run_n_i)
    );

    // core clock
    always #2.5 core_clk_i = ~core_clk_i;

    // primary clock at core/8, slow dock clock, edge history and hang limit
    always @(posedge core_clk_i) begin
        if (pri_run || pc != 3'h0) pc <= pc + 3'h1;
        dc <= dc + 7'h1;
        pri_clock_i <= pc[2];
        dock_slow_clock_i <= dc[6];
        pri_q <= pri_clock_i;
        fb_q <= sec_clock_out_o[0];
        cycles++;
        if (cycles > 20000) begin
            error_cnt++;
            final_report();
        end
    end

    task automatic check(input string what, input logic [63:0] seen, input logic [63:0] exp);
        n_compared++;
        if (seen !== exp) begin
            error_cnt++;
            $display("[FAIL] %s expected %0h seen %0h", what, exp, seen);
        end
    endtask : check

    task automatic final_report();
        if (error_cnt == 0 && n_compared > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask : final_report

    // wait for falling edges of the secondary clock
    task automatic fall(input int n);
        repeat (n) begin
            @(posedge core_clk_i);
            while (!(fb_q && !sec_clock_out_o[0])) @(posedge core_clk_i);
        end
    endtask : fall

    // five copies follow the primary clock one core cycle late
    always @(negedge core_clk_i) begin
        if (cycles > 4 && !rst_i) check("sec_clocks", sec_clock_out_o, {5{pri_q}});
    end

    // word and parity monitor, takes the oldest note at each secondary fall
    always @(posedge core_clk_i) begin
        if (fb_q && !sec_clock_out_o[0] && !rst_i) begin
            check("parity_oe", sec_parity_oe_o, prev_valid);
            if (prev_valid) check("parity", sec_parity_o, prev_par);
            prev_valid <= sec_ad_oe_o;
            if (sec_ad_oe_o === 1'b1) begin
                if (exp_q.size() == 0) check("extra_word", 1'b1, 1'b0);
                else begin
                    check("word", {sec_ad_o, sec_cmd_byte_en_n_o, sec_cmd_byte_en_oe_o},
                          {exp_q[0], 1'b1});
                    prev_par <= ^exp_q.pop_front();
                end
            end
        end
    end

    // random words, some slots left undriven
    task automatic drive_words(input int n);
        logic [35:0] w;
        logic go;
        repeat (n) begin
            fall(1);
            w = {$urandom, 4'($urandom)};
            go = 1'($urandom);
            fwd_ad_i <= w[35:4];
            fwd_cmd_byte_en_n_i <= w[3:0];
            fwd_drive_i <= go;
            if (go) exp_q.push_back(w);
        end
        fall(1);
        fwd_drive_i <= 1'b0;
        fall(3);
        check("words_left", exp_q.size(), 0);
    endtask : drive_words

    // one transaction; exp_n is the fall at which the claim shows, 8 for none
    task automatic decode(input logic [3:0] cmd, input logic other, input logic present,
                          input int exp_n, input logic exp_route);
        int n;
        isa_bridge_present_i <= present;
        fall(1);
        i_spc_sec_agent.addr_phase(cmd, other);
        fall(1);
        i_spc_sec_agent.data_phase(4'($urandom));
        n = 1;
        while (sec_dev_select_oe_o !== 1'b1 && n < 8) begin
            fall(1);
            n++;
        end
        check("claim_fall", n, exp_n);
        check("route", isa_bridge_route_flag_o, exp_route);
        check("dsel_n", sec_dev_select_n_o, exp_n == 8);
        check("run_busy", {sec_clock_run_oe_o, sec_clock_run_n_o}, 2'h2);
        i_spc_sec_agent.release_bus();
        fall(2);
        check("claim_end", {sec_dev_select_oe_o, isa_bridge_route_flag_o}, 2'h0);
    endtask : decode

    // main sequence
    initial begin
        logic [3:0] seen;
        int n;
        void'($urandom(32'h9429c4f4));
        repeat (2) @(posedge core_clk_i);
        check("reset_state", {sec_reset_n_o, sec_gnt_n_o, sec_dev_select_n_o, pri_system_error_oe_o,
              isa_bridge_route_flag_o, sec_clock_run_oe_o},
              {1'b0, spc_pkg::SPC_GNT_IDLE_N, 4'h9});
        rst_i <= 1'b0;
        i_spc_sec_agent.set_side(4'h0, 1'b1, 1'b1, 1'b1);
        fall(3);
        check("grant_in_reset", sec_gnt_n_o, 4'hF);
        dock_release_i <= 1'b1;
        repeat (3) @(posedge dock_slow_clock_i);
        check("reset_held", sec_reset_n_o, 1'b0);
        n = 0;
        while (sec_reset_n_o !== 1'b1 && n < 1000) begin
            @(posedge core_clk_i);
            n++;
        end
        check("reset_release", n < 1000, 1'b1);
        check("release_sync", fb_q, 1'b1);
        seen = 4'h0;
        repeat (8) begin
            fall(1);
            check("one_grant", $countones(~sec_gnt_n_o) <= 1, 1'b1);
            seen |= ~sec_gnt_n_o;
        end
        check("all_served", seen, 4'hF);
        check("run_req", sec_clock_run_oe_o, 1'b1);
        i_spc_sec_agent.set_side(4'hD, 1'b1, 1'b1, 1'b1);
        fall(3);
        check("sole_grant", sec_gnt_n_o, 4'hD);
        i_spc_sec_agent.set_side(4'hF, 1'b1, 1'b1, 1'b1);
        fall(4);
        check("may_stop", sec_clocks_may_stop_o, 1'b1);
        i_spc_sec_agent.set_side(4'hF, 1'b1, 1'b1, 1'b0);
        fall(2);
        check("held_run", sec_clocks_may_stop_o, 1'b0);
        i_spc_sec_agent.set_side(4'hF, 1'b1, 1'b1, 1'b1);
        for (int i = 0; i < 2; i++) begin
            fall(1);
            i_spc_sec_agent.set_side(4'hF, i != 0, i == 0, 1'b1);
            n = 0;
            repeat (40) begin
                @(posedge core_clk_i);
                if (pri_system_error_oe_o === 1'b1 && pri_system_error_n_o === 1'b0) n++;
            end
            check("serr_pulse", n, 8);
            i_spc_sec_agent.set_side(4'hF, 1'b1, 1'b1, 1'b1);
        end
        decode(spc_pkg::SPC_CMD_CFG_READ, 1'b0, 1'b1, 3, 1'b0);
        decode(spc_pkg::SPC_CMD_CFG_WRITE, 1'b0, 1'b1, 3, 1'b0);
        decode(4'h6, 1'b0, 1'b1, 5, 1'b1);
        decode(4'h7, 1'b0, 1'b0, 5, 1'b0);
        decode(4'h6, 1'b1, 1'b1, 8, 1'b0);
        drive_words(24);
        pri_run <= 1'b0;
        repeat (30) @(posedge core_clk_i);
        check("clk_stopped", sec_clock_out_o, 5'h0);
        rst_i <= 1'b1;
        #1 check("async_reset", sec_reset_n_o, 1'b0);
        final_report();
    end
endmodule : tb
`default_nettype wire
